// ---- hw/mode_control.sv ----
// Mode control of an analog computer control centre: mode select, integrator
// relay drive, repetitive cycling, overload freeze, power and board interlocks.
// Assumes every panel and pin input is asynchronous and slow; relay drivers
// outside turn the registered outputs into coil current.
`timescale 1ns/1ps
`default_nettype none

module mode_control
  import mode_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Mode push buttons
  input  wire logic        i_sel_balance,
  input  wire logic        i_sel_initial_condition,
  input  wire logic        i_sel_run,
  input  wire logic        i_sel_freeze,
  input  wire logic        i_sel_repetitive,
  // Duration selector and fine settings
  input  wire logic [1:0]  i_range_sel,
  input  wire logic [7:0]  i_run_fine,
  input  wire logic [7:0]  i_ic_fine,
  // External mode logic lines, high true
  input  wire logic        i_ext_freeze,
  input  wire logic        i_ext_run,
  input  wire logic        i_ext_initial_condition,
  // Overload
  input  wire logic        i_overload_any,
  input  wire logic        i_overload_freeze_enable,
  input  wire logic        i_overload_freeze_clear,
  // Power and interlocks
  input  wire logic        i_main_power_sw,
  input  wire logic        i_amp_power_sw,
  input  wire logic        i_overvoltage_supply,
  input  wire logic        i_overvoltage_amp,
  input  wire logic        i_board_seated,
  input  wire logic        i_arm_raised,
  // Relay drives and indicators
  output logic             o_initial_condition_relay,
  output logic             o_freeze_relay,
  output logic             o_balance_relay,
  output logic             o_potset_relay,
  output logic             o_cycle_phase,
  output logic             o_running,
  output logic             o_overload_lamp,
  output logic             o_oven_lamp,
  output logic             o_relay_supply_en,
  output logic             o_amp_power_en,
  output mode_pkg::mode_t  o_mode
);
  import mode_pkg::*;

  localparam int SW = 35;

  timer_if tif ();

  // ==========================================================================
  // Input synchronisers
  logic [SW-1:0] pins;
  logic [SW-1:0] pins_s;
  logic          b_bal, b_ic, b_run, b_frz, b_rep;
  logic [1:0]    range_s;
  logic [7:0]    run_fine_s, ic_fine_s;
  logic          ext_frz, ext_run, ext_ic;
  logic          ol_any, ol_en, ol_clr;
  logic          main_sw, amp_sw, ov_sup, ov_amp, seated, arm_up;

  // All pins in one vector so a single synchroniser covers them
  assign pins = {i_sel_balance, i_sel_initial_condition, i_sel_run,
                 i_sel_freeze, i_sel_repetitive, i_range_sel,
                 i_run_fine, i_ic_fine, i_ext_freeze, i_ext_run,
                 i_ext_initial_condition, i_overload_any,
                 i_overload_freeze_enable, i_overload_freeze_clear,
                 i_main_power_sw, i_amp_power_sw, i_overvoltage_supply,
                 i_overvoltage_amp, i_board_seated, i_arm_raised};

  pin_sync #(
    .W      (SW)
  ) u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_async(pins),
    .o_sync (pins_s)
  );

  // Unpack in the same order as packed
  assign {b_bal, b_ic, b_run, b_frz, b_rep, range_s,
          run_fine_s, ic_fine_s, ext_frz, ext_run, ext_ic,
          ol_any, ol_en, ol_clr, main_sw, amp_sw, ov_sup,
          ov_amp, seated, arm_up} = pins_s;

  // ==========================================================================
  // Edge detection of buttons and the overload re-engage control
  logic [5:0] btn_q_r, btn_q_nxt;
  logic [5:0] btn_now;
  logic [5:0] press;

  // Only a fresh press acts; a held button does not re-trigger
  always_comb
  begin
    btn_now   = {b_bal, b_ic, b_run, b_frz, b_rep, ol_clr};
    press     = btn_now & ~btn_q_r;
    btn_q_nxt = btn_now;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      btn_q_r <= '0;
    else
      btn_q_r <= btn_q_nxt;
  end

  // ==========================================================================
  // Mode selection
  mode_t mode_r, mode_nxt;

  // Priority picks a single mode even if buttons are pressed together
  always_comb
  begin
    mode_nxt = mode_r;
    if (press[5])
      mode_nxt = MODE_BAL;
    else if (press[4])
      mode_nxt = MODE_IC;
    else if (press[3])
      mode_nxt = MODE_RUN;
    else if (press[2])
      mode_nxt = MODE_FREEZE;
    else if (press[1])
      mode_nxt = MODE_REP;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      mode_r <= MODE_RESET;
    else
      mode_r <= mode_nxt;
  end

  // ==========================================================================
  // Power supplies, overvoltage latches and board interlock
  logic ov_sup_r, ov_sup_nxt;
  logic ov_amp_r, ov_amp_nxt;
  logic supply_r, supply_nxt;
  logic amp_r,    amp_nxt;
  logic board_ok;

  // A latch clears only with its switch off, so power returns on the next
  // switch-on; a new overvoltage wins over the clear
  always_comb
  begin
    ov_sup_nxt = ov_sup_r;
    ov_amp_nxt = ov_amp_r;
    if (!main_sw)
      ov_sup_nxt = 1'b0;
    if (ov_sup)
      ov_sup_nxt = 1'b1;
    if (!amp_sw)
      ov_amp_nxt = 1'b0;
    if (ov_amp)
      ov_amp_nxt = 1'b1;
    board_ok   = seated && arm_up;
    supply_nxt = main_sw && !ov_sup_r && !ov_sup;
    // Amplifier switch counts only with the relay supply up
    amp_nxt    = supply_nxt && amp_sw && !ov_amp_r && !ov_amp
                 && board_ok;
  end

  // Supply enable never looks at the amplifier switch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ov_sup_r <= 1'b0;
      ov_amp_r <= 1'b0;
      supply_r <= 1'b0;
      amp_r    <= 1'b0;
    end
    else
    begin
      ov_sup_r <= ov_sup_nxt;
      ov_amp_r <= ov_amp_nxt;
      supply_r <= supply_nxt;
      amp_r    <= amp_nxt;
    end
  end

  // ==========================================================================
  // Overload freeze latch
  logic ol_r, ol_nxt;

  // Re-engaging the control clears; a standing overload sets again at once
  always_comb
  begin
    ol_nxt = ol_r;
    if (press[0])
      ol_nxt = 1'b0;
    if (ol_en && ol_any)
      ol_nxt = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ol_r <= 1'b0;
    else
      ol_r <= ol_nxt;
  end

  // ==========================================================================
  // Overload lamp blink divider, counts base ticks and never stops
  logic [9:0] blink_cnt_r, blink_cnt_nxt;
  logic       blink_r,     blink_nxt;

  always_comb
  begin
    blink_cnt_nxt = blink_cnt_r;
    blink_nxt     = blink_r;
    if (tif.base_tick)
    begin
      if (blink_cnt_r == 10'(BLINK_HALF_TICKS - 1))
      begin
        blink_cnt_nxt = '0;
        blink_nxt     = !blink_r;
      end
      else
        blink_cnt_nxt = 10'(blink_cnt_r + 10'h001);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end
    else
    begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
    end
  end

  // ==========================================================================
  // Repetitive timer link
  logic rep_ext;

  // Internal timer runs only with power up and the selector off external
  assign rep_ext      = (mode_r == MODE_REP) && (range_s == RANGE_EXT);
  assign tif.enable   = (mode_r == MODE_REP) && !rep_ext && amp_r;
  assign tif.range    = range_s;
  assign tif.run_fine = run_fine_s;
  assign tif.ic_fine  = ic_fine_s;

  phase_timer #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_timer (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .tif          (tif.timer)
  );

  // ==========================================================================
  // Relay decode
  logic ic_nxt, frz_nxt, bal_nxt, phase_nxt, run_nxt;

  always_comb
  begin
    ic_nxt    = 1'b0;
    frz_nxt   = 1'b0;
    bal_nxt   = 1'b0;
    phase_nxt = 1'b0;
    case (mode_r)
      MODE_BAL:
        bal_nxt = 1'b1;
      MODE_IC:
        ic_nxt = 1'b1;
      MODE_RUN:
        ic_nxt = 1'b0;
      MODE_FREEZE:
        frz_nxt = 1'b1;
      MODE_REP:
      begin
        if (rep_ext)
        begin
          // Freeze line outranks IC, IC outranks run, none means run
          if (ext_frz)
            frz_nxt = 1'b1;
          else if (ext_ic)
            ic_nxt = 1'b1;
          else if (ext_run)
            ic_nxt = 1'b0;
          phase_nxt = ext_ic && !ext_frz;
        end
        else
        begin
          ic_nxt    = tif.phase_ic;
          phase_nxt = tif.phase_ic;
        end
      end
      default:
        bal_nxt = 1'b1;
    endcase
    if (ic_nxt)
      frz_nxt = 1'b1;
    if (ol_r)
      frz_nxt = 1'b1;
    // Without power or board, integrators are parked in IC and hold;
    // balance drops so two contradictory modes never share the relays
    if (!amp_r)
    begin
      ic_nxt  = 1'b1;
      frz_nxt = 1'b1;
      bal_nxt = 1'b0;
    end
    run_nxt = !ic_nxt && !frz_nxt && !bal_nxt;
  end

  // ==========================================================================
  // Output registers
  logic ic_out_r, frz_out_r, bal_out_r, phase_r, run_r, ol_lamp_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ic_out_r  <= 1'b0;
      frz_out_r <= 1'b0;
      bal_out_r <= 1'b0;
      phase_r   <= 1'b0;
      run_r     <= 1'b0;
      ol_lamp_r <= 1'b0;
    end
    else
    begin
      ic_out_r  <= ic_nxt;
      frz_out_r <= frz_nxt;
      bal_out_r <= bal_nxt;
      phase_r   <= phase_nxt;
      run_r     <= run_nxt;
      ol_lamp_r <= ol_any && blink_r;
    end
  end

  // Balance and pot-set share one drive on purpose
  assign o_initial_condition_relay = ic_out_r;
  assign o_freeze_relay            = frz_out_r;
  assign o_balance_relay           = bal_out_r;
  assign o_potset_relay            = bal_out_r;
  assign o_cycle_phase             = phase_r;
  assign o_running                 = run_r;
  assign o_overload_lamp           = ol_lamp_r;
  assign o_oven_lamp               = supply_r;
  assign o_relay_supply_en         = supply_r;
  assign o_amp_power_en            = amp_r;
  assign o_mode                    = mode_r;
endmodule // mode_control
`default_nettype wire

// ---- hw/phase_timer.sv ----
// Repetitive cycle timer: alternates initial-condition and run phases.
// Assumes the controller holds enable low outside internal repetitive cycling.
`timescale 1ns/1ps
`default_nettype none
module phase_timer
  import mode_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  timer_if.timer    tif
);
  localparam int BW = $clog2(TICK_CYCLES_P + 1);

  logic [BW-1:0] base_r,  base_nxt;
  logic          tick_r,  tick_nxt;
  logic [6:0]    dec_r,   dec_nxt;
  logic [7:0]    cnt_r,   cnt_nxt;
  logic          ic_r,    ic_nxt;
  logic [6:0]    scale;
  logic [7:0]    len;
  logic          step;

  // ==========================================================================
  // Base tick divider runs free so the blink never stops
  always_comb
  begin
    tick_nxt = (base_r == BW'(TICK_CYCLES_P - 1));
    base_nxt = tick_nxt ? '0 : BW'(base_r + 1'b1);
  end

  // Range scaling and phase counting; starts every cycle in the IC phase
  always_comb
  begin
    case (tif.range)
      RANGE_MID:  scale = 7'(SCALE_MID);
      RANGE_LONG: scale = 7'(SCALE_LONG);
      default:    scale = 7'h01;
    endcase
    len = ic_r ? phase_ticks(IC_MIN_TICKS, IC_SPAN_TICKS, tif.ic_fine)
               : phase_ticks(RUN_MIN_TICKS, RUN_SPAN_TICKS, tif.run_fine);
    step    = tick_r && (dec_r == 7'(scale - 7'h01));
    dec_nxt = dec_r;
    cnt_nxt = cnt_r;
    ic_nxt  = ic_r;
    if (!tif.enable)
    begin
      dec_nxt = '0;
      cnt_nxt = '0;
      ic_nxt  = 1'b1;
    end
    else if (tick_r)
    begin
      dec_nxt = step ? 7'h00 : 7'(dec_r + 7'h01);
      if (step)
      begin
        if (8'(cnt_r + 8'h01) >= len)
        begin
          cnt_nxt = '0;
          ic_nxt  = !ic_r;
        end
        else
          cnt_nxt = 8'(cnt_r + 8'h01);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      base_r <= '0;
      tick_r <= 1'b0;
      dec_r  <= '0;
      cnt_r  <= '0;
      ic_r   <= 1'b1;
    end
    else
    begin
      base_r <= base_nxt;
      tick_r <= tick_nxt;
      dec_r  <= dec_nxt;
      cnt_r  <= cnt_nxt;
      ic_r   <= ic_nxt;
    end
  end

  assign tif.phase_ic  = ic_r;
  assign tif.base_tick = tick_r;
endmodule // phase_timer
`default_nettype wire

// ---- hw/pin_sync.sv ----
// Two-flop synchroniser for a bundle of slow asynchronous panel inputs.
// Assumes each bit changes slowly; bits of a bus may settle one cycle apart.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // pin_sync
`default_nettype wire

// ---- inc/mode_pkg.sv ----
// Shared constants, types and helpers for the analog computer mode control.
// Assumes a single 10 MHz clock; every time below is turned into cycles or ticks here.
package mode_pkg;

  // ==========================================================================
  // Clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_US       = 500;                           // Base tick 0.5 ms
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS; // 5000 cycles
  localparam int DECADE        = 10;                            // Step between ranges
  localparam int SCALE_MID     = DECADE;
  localparam int SCALE_LONG    = DECADE * DECADE;

  // ==========================================================================
  // Phase lengths of the shortest range; the others are decades of it
  localparam int RUN_MIN_US = 5000;
  localparam int RUN_MAX_US = 100000;
  localparam int IC_MIN_US  = 5000;
  localparam int IC_MAX_US  = 50000;
  localparam logic [7:0] RUN_MIN_TICKS  = 8'(RUN_MIN_US / TICK_US);
  localparam logic [7:0] RUN_SPAN_TICKS = 8'((RUN_MAX_US - RUN_MIN_US) / TICK_US);
  localparam logic [7:0] IC_MIN_TICKS   = 8'(IC_MIN_US / TICK_US);
  localparam logic [7:0] IC_SPAN_TICKS  = 8'((IC_MAX_US - IC_MIN_US) / TICK_US);

  // Overload lamp half period, about 1.5 Hz blink
  localparam int BLINK_HALF_US    = 333000;
  localparam int BLINK_HALF_TICKS = BLINK_HALF_US / TICK_US;

  // ==========================================================================
  // Duration selector positions and operating modes
  localparam logic [1:0] RANGE_SHORT = 2'h0;
  localparam logic [1:0] RANGE_MID   = 2'h1;
  localparam logic [1:0] RANGE_LONG  = 2'h2;
  localparam logic [1:0] RANGE_EXT   = 2'h3;

  typedef enum logic [2:0] {
    MODE_BAL, MODE_IC, MODE_RUN, MODE_FREEZE, MODE_REP
  } mode_t;
  localparam mode_t MODE_RESET = MODE_BAL;

  // Phase length in ticks: minimum plus fine fraction of the span
  function automatic logic [7:0] phase_ticks(input logic [7:0] min_t,
                                             input logic [7:0] span_t,
                                             input logic [7:0] fine);
    logic [15:0] prod;
    prod = span_t * fine;
    return 8'(min_t + prod[15:8]);
  endfunction

endpackage

// ---- inc/timer_if.sv ----
// Link between the mode controller and the repetitive phase timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic       enable;     // Internal repetitive cycling active
  logic [1:0] range;      // Duration range selector
  logic [7:0] run_fine;   // Run phase fine setting
  logic [7:0] ic_fine;    // Initial-condition phase fine setting
  logic       phase_ic;   // High during initial-condition phase
  logic       base_tick;  // One-cycle pulse every base tick, free running

  modport ctrl  (output enable, range, run_fine, ic_fine,
                 input  phase_ic, base_tick);
  modport timer (input  enable, range, run_fine, ic_fine,
                 output phase_ic, base_tick);
endinterface
`default_nettype wire

// ---- tb/ext_logic_model.sv ----
// Far side model: external cycle logic lines and the IC relay driver.
// Assumes lines are high true and read false (0V) when idle.
`timescale 1ns/1ps
`default_nettype none
module ext_logic_model #(
  parameter int IC_LEN  = 6,
  parameter int RUN_LEN = 10
) (
  input  wire logic i_clk,
  input  wire logic i_gen,
  input  wire logic i_hold,
  input  wire logic i_ic_relay,
  output logic      o_ext_freeze = 1'b0,
  output logic      o_ext_run = 1'b0,
  output logic      o_ext_initial_condition = 1'b0,
  output int        o_ic_edges = 0
);
  int   cnt  = 0;
  logic last = 1'b0;

  // ==========================================================================
  // Lines move off the sampling edge so the controller never sees a race
  always @(negedge i_clk)
  begin
    cnt = (i_gen && cnt < IC_LEN + RUN_LEN - 1) ? cnt + 1 : 0;
    o_ext_initial_condition = i_gen && cnt < IC_LEN;
    o_ext_run = i_gen && cnt >= IC_LEN;
    o_ext_freeze = i_hold;
  end

  // Relay driver counts each energising of the IC coil
  always @(posedge i_clk)
  begin
    if (i_ic_relay === 1'b1 && last !== 1'b1)
      o_ic_edges++;
    last = i_ic_relay;
  end
endmodule // ext_logic_model
`default_nettype wire

// ---- tb/mode_control_sva.sv ----
// Concurrent checks on the mode controller's top-level ports.
// Assumes two-flop input synchronisers and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module mode_control_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_main_power_sw,
  input wire logic i_overvoltage_supply,
  input wire logic i_board_seated,
  input wire logic i_arm_raised,
  input wire logic i_overload_any,
  input wire logic i_overload_freeze_enable,
  input wire logic i_overload_freeze_clear,
  input wire logic o_initial_condition_relay,
  input wire logic o_freeze_relay,
  input wire logic o_balance_relay,
  input wire logic o_potset_relay,
  input wire logic o_running,
  input wire logic o_overload_lamp,
  input wire logic o_oven_lamp,
  input wire logic o_relay_supply_en,
  input wire logic o_amp_power_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // Protection events; windows allow for the synchroniser delay
  sequence s_ov_event;
    (i_overvoltage_supply && i_main_power_sw)[*4];
  endsequence
  sequence s_ol_event;
    (i_overload_any && i_overload_freeze_enable && !i_overload_freeze_clear)[*5];
  endsequence

  // ==========================================================================
  // Relay decode, power and overload checks
  a_modes_exclusive: assert property (o_balance_relay |-> !o_initial_condition_relay)
    else $error("balance and initial condition relays both on");
  a_ic_has_freeze: assert property (o_initial_condition_relay |-> o_freeze_relay)
    else $error("initial condition without freeze relay");
  a_run_all_off: assert property
    (o_running |-> !(o_initial_condition_relay || o_freeze_relay || o_balance_relay))
    else $error("running with a relay energised");
  a_potset_pair: assert property (o_potset_relay == o_balance_relay)
    else $error("pot set and balance relays differ");
  a_oven_lamp: assert property (o_oven_lamp == o_relay_supply_en)
    else $error("oven lamp differs from relay supply");
  a_amp_needs_supply: assert property (o_amp_power_en |-> o_relay_supply_en)
    else $error("amplifier power without relay supply");
  a_board_interlock: assert property
    ((!i_board_seated || !i_arm_raised)[*4] |=> !o_amp_power_en)
    else $error("amplifier power with board interlock open");
  a_ov_latch_holds: assert property
    (s_ov_event ##1 i_main_power_sw[*8] |-> !o_relay_supply_en)
    else $error("relay supply back without switch recycle");
  a_ol_forces_freeze: assert property (s_ol_event |=> o_freeze_relay)
    else $error("overload did not force freeze");
  a_ol_latch_holds: assert property
    (s_ol_event ##1 (!i_overload_freeze_clear)[*8] |-> o_freeze_relay)
    else $error("overload freeze dropped without re-engage");
  a_lamp_quiet: assert property ((!i_overload_any)[*4] |=> !o_overload_lamp)
    else $error("overload lamp on without overload");
endmodule // mode_control_sva

bind mode_control mode_control_sva mode_control_sva_inst (
  .i_clk, .i_rst, .i_main_power_sw, .i_overvoltage_supply, .i_board_seated,
  .i_arm_raised, .i_overload_any, .i_overload_freeze_enable,
  .i_overload_freeze_clear, .o_initial_condition_relay, .o_freeze_relay,
  .o_balance_relay, .o_potset_relay, .o_running, .o_overload_lamp, .o_oven_lamp,
  .o_relay_supply_en, .o_amp_power_en);
`default_nettype wire

// ---- tb/mode_control_test.sv ----
// Bench for mode_control: modes, power, interlocks, overload, cycling.
// Assumes mode_pkg; the base tick is cut to 10 cycles to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module mode_control_test;
  import mode_pkg::*;
  localparam int TK = 10;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [4:0] btn   = 5'h00;
  logic [1:0] rng   = 2'h0;
  logic [7:0] rf    = 8'h00;
  logic [7:0] icf   = 8'h00;
  logic [8:0] pin   = 9'h000; // arm seat ova ovs asw msw clr ole ovl
  logic       gen   = 1'b0;
  logic       hold  = 1'b0;
  logic       cyc, lamp, oven, sup, amp, ef, er, ei;
  logic [4:0] rq; // ic freeze bal pot run
  mode_t      mode;
  int         fails = 0, n_checks = 0, seed = 65, cyc_n = 0, edges, e0, s, lt;
  time        t;

  mode_control #(.TICK_CYCLES_P(TK)) mode_control_inst (
    .i_clk, .i_rst, .i_sel_balance(btn[0]), .i_sel_initial_condition(btn[1]),
    .i_sel_run(btn[2]), .i_sel_freeze(btn[3]), .i_sel_repetitive(btn[4]),
    .i_range_sel(rng), .i_run_fine(rf), .i_ic_fine(icf), .i_ext_freeze(ef),
    .i_ext_run(er), .i_ext_initial_condition(ei), .i_overload_any(pin[0]),
    .i_overload_freeze_enable(pin[1]), .i_overload_freeze_clear(pin[2]),
    .i_main_power_sw(pin[3]), .i_amp_power_sw(pin[4]),
    .i_overvoltage_supply(pin[5]), .i_overvoltage_amp(pin[6]),
    .i_board_seated(pin[7]), .i_arm_raised(pin[8]),
    .o_initial_condition_relay(rq[4]), .o_freeze_relay(rq[3]),
    .o_balance_relay(rq[2]), .o_potset_relay(rq[1]), .o_running(rq[0]),
    .o_cycle_phase(cyc), .o_overload_lamp(lamp), .o_oven_lamp(oven),
    .o_relay_supply_en(sup), .o_amp_power_en(amp), .o_mode(mode));

  ext_logic_model ext_logic_model_inst (
    .i_clk, .i_gen(gen), .i_hold(hold), .i_ic_relay(rq[4]), .o_ext_freeze(ef),
    .o_ext_run(er), .o_ext_initial_condition(ei), .o_ic_edges(edges));

  // ==========================================================================
  // Clock and a hang guard at 100000 cycles, only a little above the longest expected run
  initial
    forever #50 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc_n++;
    if (cyc_n == 100000)
    begin
      fails++;
      conclude();
    end
  end

  // ==========================================================================
  // Reference model and helpers; unpowered means parked in IC plus freeze
  function automatic logic [4:0] model(mode_t m, logic op, logic ol);
    logic [4:0] r;
    case (m)
      MODE_BAL: r = 5'h06;
      MODE_IC:  r = 5'h18;
      MODE_RUN: r = 5'h01;
      default:  r = 5'h08;
    endcase
    if (ol)
      r = (r | 5'h08) & 5'h1E;
    return op ? r : 5'h18;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Hold long enough to pass the synchroniser, then release fully
  task automatic press(int b);
    btn[b] = 1'b1;
    wt(5);
    btn = 5'h00;
    wt(8);
  endtask
  task automatic pv(logic es, logic ea);
    wt(8);
    chk("supply", es, sup);
    chk("oven", es, oven);
    chk("amp", ea, amp);
  endtask
  // Times one full IC phase and one run phase at the cycle output
  task automatic ph(int r);
    s = (r == 0) ? TK : (r == 1) ? 10 * TK : 100 * TK;
    @(posedge cyc);
    t = $time;
    @(negedge cyc);
    chk("ic time", 16'((10 + ((90 * icf) >> 8)) * s), 16'(($time - t) / 100));
    t = $time;
    wt(1);
    chk("phase", 0, cyc);
    chk("relays", model(MODE_RUN, 1, 0), rq);
    @(posedge cyc);
    chk("run time", 16'((10 + ((190 * rf) >> 8)) * s), 16'(($time - t) / 100));
    wt(2);
    chk("phase", 1, cyc);
    chk("relays", model(MODE_IC, 1, 0), rq);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    wt(5);
    i_rst = 1'b0;
    wt(6);
    chk("mode", MODE_BAL, mode);
    chk("relays", model(MODE_BAL, 0, 0), rq);
    pin = 9'h190;
    pv(0, 0);
    pin[3] = 1'b1;
    pv(1, 1);
    for (int i = 0; i < 4; i++)
    begin
      press(i);
      chk("mode", 16'(i), mode);
      chk("relays", model(mode_t'(i), 1, 0), rq);
    end
    press(2);
    chk("relays", model(MODE_RUN, 1, 0), rq);
    pin[4] = 1'b0;
    pv(1, 0);
    chk("relays", model(MODE_RUN, 0, 0), rq);
    pin[3] = 1'b0;
    pin[4] = 1'b1;
    pv(0, 0);
    pin[3] = 1'b1;
    pin[7] = 1'b0;
    pv(1, 0);
    pin[8:7] = 2'h1;
    pv(1, 0);
    pin[8] = 1'b1;
    pin[5] = 1'b1;
    wt(4);
    pin[5] = 1'b0;
    pv(0, 0);
    pin[3] = 1'b0;
    wt(8);
    pin[3] = 1'b1;
    pv(1, 1);
    pin[6] = 1'b1;
    wt(4);
    pin[6] = 1'b0;
    pv(1, 0);
    pin[4] = 1'b0;
    wt(8);
    pin[4] = 1'b1;
    pv(1, 1);
    pin[1:0] = 2'h3;
    wt(8);
    chk("relays", model(MODE_RUN, 1, 1), rq);
    lt = 0;
    repeat (14000)
    begin
      @(negedge i_clk);
      lt += (lamp === 1'b1);
    end
    chk("blink", 1, lt > 5000 && lt < 9000);
    pin[0] = 1'b0;
    wt(8);
    chk("lamp", 0, lamp);
    chk("relays", model(MODE_RUN, 1, 1), rq);
    pin[2] = 1'b1;
    wt(8);
    chk("relays", model(MODE_RUN, 1, 0), rq);
    press(4);
    for (int r = 0; r < 3; r++)
    begin
      rng = 2'(r);
      rf = (r == 2) ? 8'h00 : 8'($random(seed)) & 8'h3F;
      icf = (r == 2) ? 8'h00 : 8'($random(seed));
      wt(8);
      ph(r);
    end
    rng = RANGE_EXT;
    gen = 1'b1;
    wt(20);
    e0 = edges;
    wt(200);
    chk("ext cycles", 1, (edges - e0) > 10);
    hold = 1'b1;
    wt(8);
    chk("relays", model(MODE_FREEZE, 1, 0), rq);
    gen = 1'b0;
    hold = 1'b0;
    wt(8);
    chk("relays", model(MODE_RUN, 1, 0), rq);
    conclude();
  end
endmodule // mode_control_test
`default_nettype wire
